// >>> design/smhp_consts.vh
// Purpose: Constants for the serial-mode host port and pattern pin block.
// Assumes: Byte addresses on an 8-bit APB address, one word per register.
// Notes:   Included by smhp_top.v only.
`ifndef SMHP_CONSTS_VH
`define SMHP_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SMHP_OFF_CTRL_LINE   8'h00
`define SMHP_OFF_CTRL_BACKPLANE_CLOCK  8'h04
`define SMHP_OFF_CTRL_REPORT 8'h08
`define SMHP_OFF_ERR_ONE     8'h0c
`define SMHP_OFF_ERR_TWO     8'h10
`define SMHP_OFF_IRQ_STATUS  8'h14
`define SMHP_OFF_IRQ_MASK    8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SMHP_POS_LINE_STD    7
`define SMHP_POS_RATE_HI     7
`define SMHP_POS_RATE_LO     6
`define SMHP_POS_REPORT_EN   2
`define SMHP_POS_ST_SYNC     0
`define SMHP_POS_ST_ERROR    1
`define SMHP_POS_ST_LIVE     7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SMHP_RST_CTRL        8'h00
`define SMHP_RST_IRQ         2'h0
`define SMHP_RST_ERRCNT      16'h0000
`define SMHP_RST_SYNC        11'h600

// ----------------------------------------------------------------------
// Backplane clock phase increments for a 50 MHz pclk
// ----------------------------------------------------------------------
`define SMHP_INC_16M384      32'h53e2d620
`define SMHP_INC_8M192       32'h29f16b10
`define SMHP_INC_4M096       32'h14f8b588
`define SMHP_INC_2M048       32'h0a7c5ac4

// ----------------------------------------------------------------------
// Pattern synchroniser and serial port counts
// ----------------------------------------------------------------------
`define SMHP_SYNC_GOOD       6'h20
`define SMHP_SYNC_BAD        3'h4
`define SMHP_SP_LAST         5'h0f
`define SMHP_SP_ADDR_LAST    5'h07

`endif

// >>> design/smhp_top.v
// Purpose: Serial host port, reset, alert, backplane clock and pattern
//          error logic of a line interface unit, with an APB register view.
// Assumes: All non-APB pins are asynchronous to pclk and are synchronised first.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - Serial port activity counts only while chip select is held low.
// - Serial input sampled on rising edge if select is 0, falling if 1.
// - Serial output valid on rising edge if select is 0, falling if 1.
// - Backplane clock rate 16.384/8.192/4.096/2.048 MHz from two rate bits.
// - In hardware mode the backplane clock runs at 16.384 MHz.
// - Hardware reset low returns every control bit to zero.
// - Open-drain active-low alert while unmasked status conditions are present.
// - Receiver hunts for 2^15-1 or 2^20-1 pattern per line standard bit.
// - Pattern error output high out of sync, low once synchronised.
// - Each bit error in sync gives a one bit period high pulse.
// - With report enable set, bit errors in sync accumulate in error counters.
// - Recovered clock out follows the line, else the master clock.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`include "smhp_consts.vh"

module smhp_top #(
	parameter ADDR_W = 8
) (
	// APB slave
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// Serial host port pins
	input  wire              cs_n,
	input  wire              sclk,
	input  wire              serial_in,
	input  wire              input_edge_select,
	input  wire              output_edge_select,
	output reg               serial_out,
	output reg               serial_out_oe,
	// Reset, mode and alert pins
	input  wire              hardware_reset_n,
	input  wire              hw_mode,
	output reg               alert_n_out,
	output reg               alert_n_oe,
	output reg               irq,
	// Line side pins
	input  wire              mclk,
	input  wire              rclk_in,
	input  wire              rx_data,
	input  wire              line_signal_present,
	output reg               rclk_out,
	output reg               backplane_clock,
	output reg               pattern_error_out
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	localparam S_HARDWARE_RESET_N = 10, S_CS = 9, S_SCLK = 8, S_SIN = 7, S_IES = 6;
	localparam S_OES = 5, S_RCLK = 4, S_RXD = 3, S_MCLK = 2, S_SIG = 1;
	localparam S_HW = 0;

	reg  [10:0] pin_meta_reg;
	reg  [10:0] pin_sync_reg;
	reg         sclk_prev_reg;
	reg         rclk_prev_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg  <= `SMHP_RST_SYNC;
			pin_sync_reg  <= `SMHP_RST_SYNC;
			sclk_prev_reg <= 1'b0;
			rclk_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg  <= {hardware_reset_n, cs_n, sclk, serial_in,
				input_edge_select, output_edge_select, rclk_in, rx_data,
				mclk, line_signal_present, hw_mode};
			pin_sync_reg  <= pin_meta_reg;
			sclk_prev_reg <= pin_sync_reg[S_SCLK];
			rclk_prev_reg <= pin_sync_reg[S_RCLK];
		end
	end

	wire hardware_reset_n_n    = pin_sync_reg[S_HARDWARE_RESET_N];
	wire cs_act    = ~pin_sync_reg[S_CS];
	wire sclk_rise = pin_sync_reg[S_SCLK] & ~sclk_prev_reg;
	wire sclk_fall = ~pin_sync_reg[S_SCLK] & sclk_prev_reg;
	wire rclk_rise = pin_sync_reg[S_RCLK] & ~rclk_prev_reg;
	wire sp_sample = pin_sync_reg[S_IES] ? sclk_fall : sclk_rise;
	wire sp_launch = pin_sync_reg[S_OES] ? sclk_fall : sclk_rise;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	reg  [7:0]  ctrl_line_reg;
	reg  [7:0]  ctrl_backplane_clock_reg;
	reg  [7:0]  ctrl_report_reg;
	reg  [1:0]  irq_status_reg;
	reg  [1:0]  irq_mask_reg;
	reg  [15:0] err_cnt_reg;
	reg         sync_reg;

	function [8:0] smhp_read;
		input [7:0] addr;
		begin
			case (addr)
				`SMHP_OFF_CTRL_LINE:   smhp_read = {1'b1, ctrl_line_reg};
				`SMHP_OFF_CTRL_BACKPLANE_CLOCK:  smhp_read = {1'b1, ctrl_backplane_clock_reg};
				`SMHP_OFF_CTRL_REPORT: smhp_read = {1'b1, ctrl_report_reg};
				`SMHP_OFF_ERR_ONE:     smhp_read = {1'b1, err_cnt_reg[15:8]};
				`SMHP_OFF_ERR_TWO:     smhp_read = {1'b1, err_cnt_reg[7:0]};
				`SMHP_OFF_IRQ_STATUS:  smhp_read = {1'b1, sync_reg, 5'h00,
					irq_status_reg};
				`SMHP_OFF_IRQ_MASK:    smhp_read = {1'b1, 6'h00,
					irq_mask_reg};
				default:               smhp_read = 9'h000;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Serial host port
	// ------------------------------------------------------------------
	reg  [4:0]  sp_cnt_reg;
	reg  [15:0] sp_sh_reg;
	reg  [7:0]  sp_out_reg;
	reg         sp_rd_reg;

	wire [15:0] sp_word = {sp_sh_reg[14:0], pin_sync_reg[S_SIN]};
	wire [8:0]  sp_rdata = sp_word[6] ? 9'h000 :
		smhp_read({sp_word[5:0], 2'b00});
	wire        sp_wr = cs_act & sp_sample & (sp_cnt_reg == `SMHP_SP_LAST) &
		~sp_word[15] & ~sp_word[14];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_cnt_reg    <= 5'h00;
			sp_sh_reg     <= 16'h0000;
			sp_out_reg    <= 8'h00;
			sp_rd_reg     <= 1'b0;
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (!cs_act) begin
			sp_cnt_reg    <= 5'h00;
			sp_rd_reg     <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			if (sp_sample && sp_cnt_reg <= `SMHP_SP_LAST) begin
				sp_sh_reg  <= sp_word;
				sp_cnt_reg <= sp_cnt_reg + 5'h01;
				if (sp_cnt_reg == `SMHP_SP_ADDR_LAST && sp_word[7]) begin
					sp_out_reg <= sp_rdata[7:0];
					sp_rd_reg  <= 1'b1;
				end
			end
			if (sp_launch && sp_rd_reg) begin
				serial_out    <= sp_out_reg[7];
				sp_out_reg    <= {sp_out_reg[6:0], 1'b0};
				serial_out_oe <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	wire [8:0] apb_rdata = smhp_read(paddr[7:0]);
	wire       apb_wr    = psel & penable & pready & pwrite;
	wire       wr_en     = apb_wr | sp_wr;
	wire [7:0] wr_addr   = apb_wr ? paddr[7:0] : {sp_word[13:8], 2'b00};
	wire [7:0] wr_data   = apb_wr ? pwdata[7:0] : sp_word[7:0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~apb_rdata[8];
			if (psel && !penable) begin
				prdata <= {24'h000000, apb_rdata[7:0]};
			end
		end
	end

	// ------------------------------------------------------------------
	// Pattern checker
	// ------------------------------------------------------------------
	reg  [19:0] prbs_reg;
	reg  [5:0]  good_cnt_reg;
	reg  [2:0]  bad_cnt_reg;
	reg         sync_next;
	reg  [5:0]  good_next;
	reg  [2:0]  bad_next;

	wire line_bit = pin_sync_reg[S_RXD];
	wire long_pat = ctrl_line_reg[`SMHP_POS_LINE_STD];
	wire predict  = long_pat ? (prbs_reg[19] ^ prbs_reg[16]) :
		(prbs_reg[14] ^ prbs_reg[13]);
	wire bit_err  = rclk_rise & (predict != line_bit);
	wire sync_err = bit_err & sync_reg;
	wire sync_chg = rclk_rise & (sync_next != sync_reg);

	always @* begin
		sync_next = sync_reg;
		good_next = good_cnt_reg;
		bad_next  = bad_cnt_reg;
		if (predict == line_bit) begin
			good_next = good_cnt_reg + 6'h01;
			if (!sync_reg && good_next == `SMHP_SYNC_GOOD) begin
				sync_next = 1'b1;
				good_next = 6'h00;
			end else if (sync_reg && good_next == `SMHP_SYNC_GOOD) begin
				bad_next  = 3'h0;
				good_next = 6'h00;
			end
		end else begin
			good_next = 6'h00;
			if (sync_reg) begin
				bad_next = bad_cnt_reg + 3'h1;
				if (bad_next == `SMHP_SYNC_BAD) begin
					sync_next = 1'b0;
					bad_next  = 3'h0;
				end
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prbs_reg          <= 20'h00000;
			good_cnt_reg      <= 6'h00;
			bad_cnt_reg       <= 3'h0;
			sync_reg          <= 1'b0;
			pattern_error_out <= 1'b1;
		end else if (rclk_rise) begin
			prbs_reg          <= {prbs_reg[18:0], line_bit};
			good_cnt_reg      <= good_next;
			bad_cnt_reg       <= bad_next;
			sync_reg          <= sync_next;
			pattern_error_out <= ~sync_next | sync_err;
		end
	end

	// ------------------------------------------------------------------
	// Control, counters and interrupt
	// ------------------------------------------------------------------
	wire [1:0] irq_set = {sync_err, sync_chg};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_line_reg   <= `SMHP_RST_CTRL;
			ctrl_backplane_clock_reg  <= `SMHP_RST_CTRL;
			ctrl_report_reg <= `SMHP_RST_CTRL;
			irq_mask_reg    <= `SMHP_RST_IRQ;
			irq_status_reg  <= `SMHP_RST_IRQ;
			err_cnt_reg     <= `SMHP_RST_ERRCNT;
		end else if (!hardware_reset_n_n) begin
			ctrl_line_reg   <= `SMHP_RST_CTRL;
			ctrl_backplane_clock_reg  <= `SMHP_RST_CTRL;
			ctrl_report_reg <= `SMHP_RST_CTRL;
			irq_mask_reg    <= `SMHP_RST_IRQ;
			irq_status_reg  <= `SMHP_RST_IRQ;
			err_cnt_reg     <= `SMHP_RST_ERRCNT;
		end else begin
			if (wr_en && wr_addr == `SMHP_OFF_CTRL_LINE)
				ctrl_line_reg <= wr_data;
			if (wr_en && wr_addr == `SMHP_OFF_CTRL_BACKPLANE_CLOCK)
				ctrl_backplane_clock_reg <= wr_data;
			if (wr_en && wr_addr == `SMHP_OFF_CTRL_REPORT)
				ctrl_report_reg <= wr_data;
			if (wr_en && wr_addr == `SMHP_OFF_IRQ_MASK)
				irq_mask_reg <= wr_data[1:0];
			if (wr_en && wr_addr == `SMHP_OFF_IRQ_STATUS)
				irq_status_reg <= (irq_status_reg & ~wr_data[1:0]) | irq_set;
			else
				irq_status_reg <= irq_status_reg | irq_set;
			if (ctrl_report_reg[`SMHP_POS_REPORT_EN] && sync_err &&
				err_cnt_reg != 16'hffff)
				err_cnt_reg <= err_cnt_reg + 16'h0001;
			else if (wr_en && wr_addr == `SMHP_OFF_ERR_ONE)
				err_cnt_reg <= `SMHP_RST_ERRCNT;
		end
	end

	wire irq_any = |(irq_status_reg & irq_mask_reg);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq         <= 1'b0;
			alert_n_out <= 1'b0;
			alert_n_oe  <= 1'b0;
		end else begin
			irq         <= irq_any;
			alert_n_out <= 1'b0;
			alert_n_oe  <= irq_any;
		end
	end

	// ------------------------------------------------------------------
	// Backplane clock and recovered clock output
	// ------------------------------------------------------------------
	reg  [31:0] bp_acc_reg;
	reg  [31:0] bp_inc;

	always @* begin
		case ({ctrl_backplane_clock_reg[`SMHP_POS_RATE_HI],
			ctrl_backplane_clock_reg[`SMHP_POS_RATE_LO]} & {2{~pin_sync_reg[S_HW]}})
			2'b00:   bp_inc = `SMHP_INC_16M384;
			2'b01:   bp_inc = `SMHP_INC_8M192;
			2'b10:   bp_inc = `SMHP_INC_4M096;
			2'b11:   bp_inc = `SMHP_INC_2M048;
			default: bp_inc = `SMHP_INC_16M384;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bp_acc_reg      <= 32'h00000000;
			backplane_clock <= 1'b0;
			rclk_out        <= 1'b0;
		end else begin
			bp_acc_reg      <= rclk_rise ? 32'h00000000 :
				bp_acc_reg + bp_inc;
			backplane_clock <= bp_acc_reg[31];
			rclk_out        <= pin_sync_reg[S_SIG] ?
				pin_sync_reg[S_RCLK] : pin_sync_reg[S_MCLK];
		end
	end

endmodule // smhp_top

// >>> tb/smhp_props.sv
// Purpose: Pin level checks on smhp_top.
// Assumes: One pclk domain.
// Notes:   Attached by bind.
`timescale 1ns/1ns
module smhp_props (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Pins
	input wire cs_n,
	input wire serial_out_oe,
	input wire hw_mode,
	input wire mclk,
	input wire rclk_in,
	input wire line_signal_present,
	input wire irq,
	input wire alert_n_out,
	input wire alert_n_oe,
	input wire rclk_out,
	input wire backplane_clock,
	input wire pattern_error_out
);
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_alert_drive_low: assert property (alert_n_out == 1'b0)
		else $error("alert drives high");
	a_alert_on_irq: assert property ($rose(irq) |-> ##[0:2] alert_n_oe)
		else $error("no alert");
	a_oe_needs_cs: assert property ($rose(serial_out_oe) |-> !cs_n)
		else $error("oe without cs");
	a_oe_off_idle: assert property (cs_n [*5] |-> !serial_out_oe)
		else $error("oe while idle");
	a_rclk_from_mclk: assert property ((!line_signal_present) [*6] ##0
		$rose(mclk) |-> ##[1:4] rclk_out) else $error("rclk not mclk");
	a_rclk_from_line: assert property (line_signal_present [*6] ##0
		$rose(rclk_in) |-> ##[1:4] rclk_out) else $error("rclk not line");
	a_bp_hw_fast: assert property (hw_mode [*8] ##1
		backplane_clock [*2] |=> !backplane_clock) else $error("slow bp");
	a_pattern_quiet: assert property ((!rclk_in) [*6] |=>
		$stable(pattern_error_out)) else $error("error out moved");
	cover property ($rose(serial_out_oe));
	cover property ($fell(pattern_error_out));
	cover property ($rose(irq));
endmodule // smhp_props

bind smhp_top smhp_props u_props (.pclk(pclk), .presetn(presetn),
	.cs_n(cs_n), .serial_out_oe(serial_out_oe), .hw_mode(hw_mode),
	.mclk(mclk), .rclk_in(rclk_in), .irq(irq),
	.line_signal_present(line_signal_present), .alert_n_out(alert_n_out),
	.alert_n_oe(alert_n_oe), .rclk_out(rclk_out),
	.backplane_clock(backplane_clock), .pattern_error_out(pattern_error_out));

// >>> tb/smhp_host_model.sv
// Purpose: Serial port host controller.
// Assumes: Sample and launch on the same edge.
// Notes:   Clock stands still between frames.
`timescale 1ns/1ns
module smhp_host_model (
	// Clock
	input wire pclk,
	// Serial port
	output logic cs_n = 1'b1,
	output logic sclk = 1'b1,
	output logic serial_in = 1'b0,
	output logic input_edge_select = 1'b0,
	output logic output_edge_select = 1'b0,
	input wire serial_out,
	input wire serial_out_oe
);
	task automatic set_edges(input logic e);
		@(posedge pclk);
		input_edge_select <= e;
		output_edge_select <= e;
		sclk <= ~e;
	endtask
	task automatic xfer(input logic en, input logic rd,
		input logic [6:0] idx, input logic [7:0] wd, output logic [7:0] rv);
		logic [15:0] fr;
		fr = {rd, idx, wd};
		rv = 8'h00;
		@(posedge pclk);
		cs_n <= ~en;
		for (int i = 15; i >= 0; i--) begin
			@(posedge pclk);
			sclk <= input_edge_select;
			serial_in <= fr[i];
			repeat (6) @(posedge pclk);
			sclk <= ~input_edge_select;
			repeat (4) @(posedge pclk);
			if (rd && i < 8)
				rv[i] = serial_out_oe ? serial_out : ~serial_out;
		end
		cs_n <= 1'b1;
		serial_in <= ~serial_in;
	endtask
endmodule // smhp_host_model

// >>> tb/tb.sv
// Purpose: Self-checking bench for smhp_top.
// Assumes: 50 MHz pclk, 160 ns line bits.
// Notes:   Host model drives the serial port.
`timescale 1ns/1ns
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, serial_out, serial_out_oe;
	wire cs_n, sclk, serial_in, input_edge_select, output_edge_select;
	logic hardware_reset_n = 1'b1;
	logic hw_mode = 1'b0;
	logic mclk = 1'b0;
	logic rclk_in = 1'b0;
	logic rx_data = 1'b0;
	logic line_signal_present = 1'b0;
	logic alert_n_out, alert_n_oe, irq, rclk_out, bp, pattern_error_out;
	logic prev_bp = 1'b0;
	logic std20 = 1'b0;
	logic [19:0] sh = 20'h00001;
	logic [7:0] rv, mc = 8'h00;
	logic [31:0] d;
	logic er;
	int num_errors = 0;
	int compares = 0;
	int hi_cnt = 0;
	int edges = 0;
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		mc <= (mc == 8'h0b) ? 8'h00 : mc + 8'h01;
		if (mc == 8'h0b)
			mclk <= ~mclk;
		prev_bp <= bp;
		if (bp && !prev_bp)
			edges++;
		if (pattern_error_out)
			hi_cnt++;
	end
	smhp_host_model host (.pclk(pclk), .cs_n(cs_n), .sclk(sclk),
		.serial_in(serial_in), .input_edge_select(input_edge_select),
		.output_edge_select(output_edge_select), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe));
	smhp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
		.sclk(sclk), .serial_in(serial_in),
		.input_edge_select(input_edge_select),
		.output_edge_select(output_edge_select), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .hardware_reset_n(hardware_reset_n),
		.hw_mode(hw_mode), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
		.irq(irq), .mclk(mclk), .rclk_in(rclk_in), .rx_data(rx_data),
		.line_signal_present(line_signal_present), .rclk_out(rclk_out),
		.backplane_clock(bp), .pattern_error_out(pattern_error_out));
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		d = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(d, e);
	endtask
	task automatic all_zero;
		for (int a = 0; a < 7; a++)
			rd_chk(8'(a * 4), 32'h0);
	endtask
	task automatic bp_meas(input int e);
		repeat (20) @(posedge pclk);
		edges = 0;
		repeat (1000) @(posedge pclk);
		check(32'(edges > e - 3 && edges < e + 3), 32'h1);
	endtask
	task automatic line_bits(input int n, input int bad);
		logic nb;
		for (int i = 0; i < n; i++) begin
			nb = std20 ? sh[16] ^ sh[19] : sh[13] ^ sh[14];
			sh = {sh[18:0], nb};
			@(posedge pclk);
			rclk_in <= 1'b0;
			rx_data <= nb ^ (i == bad);
			repeat (3) @(posedge pclk);
			rclk_in <= 1'b1;
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		all_zero;
		apb(1'b0, 8'h1c, 32'h0);
		check({31'h0, er}, 32'h1);
		for (int m = 0; m < 2; m++) begin
			host.set_edges(m[0]);
			host.xfer(1'b1, 1'b0, 7'h01, {m[0], 7'h40}, rv);
			rd_chk(8'h04, {24'h0, m[0], 7'h40});
			host.xfer(1'b0, 1'b0, 7'h01, 8'h00, rv);
			rd_chk(8'h04, {24'h0, m[0], 7'h40});
			host.xfer(1'b1, 1'b1, 7'h01, 8'h00, rv);
			check({24'h0, rv}, {24'h0, m[0], 7'h40});
		end
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, 8'h04, {24'h0, r[1:0], 6'h0});
			bp_meas(328 >> r);
		end
		hw_mode <= 1'b1;
		bp_meas(328);
		hw_mode <= 1'b0;
		apb(1'b1, 8'h18, 32'h3);
		hardware_reset_n <= 1'b0;
		repeat (5) @(posedge pclk);
		hardware_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		all_zero;
		line_signal_present <= 1'b1;
		apb(1'b1, 8'h08, 32'h04);
		apb(1'b1, 8'h18, 32'h02);
		line_bits(60, -1);
		check({31'h0, pattern_error_out}, 32'h0);
		rd_chk(8'h14, 32'h81);
		check({31'h0, irq}, 32'h0);
		hi_cnt = 0;
		line_bits(20, 2);
		check(hi_cnt, 32'd24);
		check({31'h0, irq}, 32'h1);
		rd_chk(8'h10, 32'h3);
		apb(1'b1, 8'h14, 32'h3);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		std20 = 1'b1;
		apb(1'b1, 8'h00, 32'h80);
		line_bits(120, -1);
		check({31'h0, pattern_error_out}, 32'h0);
		line_signal_present <= 1'b0;
		repeat (100) @(posedge pclk);
		give_verdict;
	end
endmodule // tb
